// *** ods_dwell.sv ***
`timescale 1ns/1ps
// Millisecond dwell timer, one-cycle done pulse at expiry
module ods_dwell #(
    parameter int UNIT_CYC = 25000
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic load,
    input wire logic abort,
    input wire logic [15:0] ms,
    output logic done
);
    logic [15:0] ms_q;
    logic [31:0] pre_q;
    logic run_q;

    // Prescaler divides the clock to dwell units
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ms_q <= 16'h0000;
            pre_q <= 32'h0;
            run_q <= 1'b0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (abort) begin
                run_q <= 1'b0;
            end else if (load) begin
                run_q <= 1'b1;
                ms_q <= ms;
                pre_q <= 32'(UNIT_CYC - 1);
            end else if (run_q) begin
                if (ms_q == 16'h0000) begin
                    run_q <= 1'b0;
                    done <= 1'b1;
                end else if (pre_q == 32'h0) begin
                    pre_q <= 32'(UNIT_CYC - 1);
                    ms_q <= ms_q - 16'h0001;
                end else begin
                    pre_q <= pre_q - 32'h1;
                end
            end
        end
    end
endmodule

// *** ods_far.sv ***
`timescale 1ns/1ps
module ods_far
    import ods_pkg::*;
(
    input wire logic pclk,
    input wire logic ready,
    input wire logic mot_launch,
    output ods_pkg::ods_pins_t pins,
    output logic mot_target_reached,
    output logic mot_stopped
);
    int cnt;

    initial begin
        pins = '0;
        mot_target_reached = 1'b0;
        mot_stopped = 1'b0;
        cnt = 0;
    end

    // Each launch restarts the move, so a blended launch never sees a stop pulse
    always @(posedge pclk) begin
        cnt <= mot_launch ? 6 : ((cnt > 0) ? cnt - 1 : 0);
        mot_target_reached <= (cnt == 4);
        mot_stopped <= (cnt == 1);
    end

    task automatic servo(input logic v);
        @(posedge pclk);
        pins.servo_on <= v;
    endtask

    // Ready is sampled on the falling edge so the pin change never races the design
    task automatic start_req(input logic [7:0] num, input logic use_step);
        int k;
        @(posedge pclk);
        pins.sel <= num;
        k = 0;
        do begin @(negedge pclk); k++; end while (ready !== 1'b1 && k < 500);
        @(posedge pclk);
        if (use_step) begin
            pins.step <= 1'b1;
        end else begin
            pins.start <= 1'b1;
        end
        k = 0;
        do begin @(negedge pclk); k++; end while (ready !== 1'b0 && k < 60);
        @(posedge pclk);
        pins.start <= 1'b0;
        pins.step <= 1'b0;
        @(posedge pclk);
    endtask
endmodule

// *** ods_pkg.sv ***
// Functional notes
// - No-link entry runs once, then the sequence ends without advancing.
// - Manual mode: each step request launches the current entry's linked successor.
// - After a manual entry finishes, busy stays high in a waiting state.
// - Step request while busy runs the successor of the entry just completed.
// - Step request while not busy runs the entry on the data-select inputs.
// - Start request drops ready, raises busy and launches the selected entry.
// - Manual mode: ready returns high after each entry, busy stays high.
// - Chain end: busy drops and ready rises.
// - Automatic mode: stop for the entry's dwell time, then launch the successor.
// - Automatic and continuous chains run until a no-link entry completes.
// - Continuous mode passes to the successor without stopping the motor.
// - Continuous switch happens at target reached; speed ramps from present speed.
// - Entering a linked entry uses that entry's acceleration rate.
// - Reversal into the next entry decelerates with that entry's stopping rate.
// - Final stop of a continuous chain uses the last entry's stopping rate.
// - Mid-chain reversal may overshoot; reversal starts after the target.
// - Link field: 0 none, 1 manual, 2 automatic, 3 continuous.
// - Next field: -256 stop, -1 following, -2 one after, 0..255 absolute.
package ods_pkg;

    // Clock and dwell timing
    localparam int CLK_PERIOD_NS = 40;
    localparam int DWELL_UNIT_NS = 1000000;
    localparam int DWELL_UNIT_CYC = DWELL_UNIT_NS / CLK_PERIOD_NS;

    // APB register byte offsets
    localparam logic [7:0] OFF_ENTRY_SEL = 8'h00;
    localparam logic [7:0] OFF_ENTRY_LINK = 8'h04;
    localparam logic [7:0] OFF_ENTRY_DWELL = 8'h08;
    localparam logic [7:0] OFF_ENTRY_RATE = 8'h0c;
    localparam logic [7:0] OFF_STATUS = 8'h10;

    // Field positions
    localparam int LINK_MODE_LSB = 0;
    localparam int LINK_NEXT_LSB = 8;
    localparam int LINK_REV_BIT = 24;
    localparam int RATE_ACC_LSB = 0;
    localparam int RATE_DEC_LSB = 16;
    localparam int ST_READY_BIT = 0;
    localparam int ST_BUSY_BIT = 1;
    localparam int ST_STATE_LSB = 4;
    localparam int ST_ENTRY_LSB = 8;

    // Link mode encoding
    typedef enum logic [1:0] {
        LINK_NONE = 2'h0,
        LINK_MANUAL = 2'h1,
        LINK_AUTO = 2'h2,
        LINK_CONT = 2'h3
    } ods_link_t;

    // Next-number codes
    localparam logic signed [9:0] NEXT_STOP = 10'sh300;
    localparam logic signed [9:0] NEXT_REL1 = 10'sh3ff;
    localparam logic signed [9:0] NEXT_REL2 = 10'sh3fe;

    typedef struct packed {
        ods_link_t link;
        logic signed [9:0] next;
        logic rev;
        logic [15:0] dwell;
        logic [15:0] accel;
        logic [15:0] decel;
    } ods_entry_t;

    // Entry defaults after reset
    localparam ods_entry_t ENTRY_RST = '{LINK_NONE, NEXT_REL1, 1'b0, 16'h0000, 16'h0000, 16'h0000};

    // Command to the motion profile generator
    typedef struct packed {
        logic [7:0] entry;
        logic [15:0] accel;
        logic [15:0] decel;
        logic rev;
        logic blend;
    } ods_cmd_t;

    // Host pins before synchronisation
    typedef struct packed {
        logic servo_on;
        logic start;
        logic step;
        logic [7:0] sel;
    } ods_pins_t;

endpackage

// *** ods_seq.sv ***
// Added by the designer: the APB register port and the placing of the registers.
`timescale 1ns/1ps
module ods_seq
    import ods_pkg::*;
#(
    parameter int DWELL_UNIT = ods_pkg::DWELL_UNIT_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire ods_pkg::ods_pins_t pins,
    output logic ready,
    output logic sequence_busy_flag,
    input wire logic mot_target_reached,
    input wire logic mot_stopped,
    output logic mot_launch,
    output ods_pkg::ods_cmd_t mot_cmd
);
    import ods_pkg::*;

    typedef enum logic [1:0] {S_IDLE, S_RUN, S_DWELL, S_WAIT} ods_state_t;

    ods_entry_t table_q [256];
    ods_pins_t pins_s;
    ods_state_t state_q, state_d;
    logic [7:0] cur_q, sel_q;
    logic start_prev_q, step_prev_q;
    logic start_rise, step_rise, servo_on;
    logic [31:0] prdata_q;
    logic err_q;
    logic ready_q, busy_q;
    logic launch_q;
    ods_cmd_t cmd_q;
    logic dwell_done;

    // Host pins come from another domain
    ods_sync #(.W($bits(ods_pins_t))) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .d(pins),
        .q(pins_s)
    );

    // Edge detection on the synchronised requests
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            start_prev_q <= 1'b0;
            step_prev_q <= 1'b0;
        end else begin
            start_prev_q <= pins_s.start;
            step_prev_q <= pins_s.step;
        end
    end

    assign servo_on = pins_s.servo_on;
    assign start_rise = pins_s.start && !start_prev_q;
    assign step_rise = pins_s.step && !step_prev_q;

    // Current entry fields and successor decode
    ods_entry_t cur_e;
    logic [8:0] rel_sum;
    logic succ_ok;
    logic [7:0] succ;
    assign cur_e = table_q[cur_q];
    assign rel_sum = {1'b0, cur_q} + ((cur_e.next == NEXT_REL2) ? 9'h002 : 9'h001);
    assign succ_ok = (cur_e.next >= 0) ? 1'b1 :
        ((cur_e.next == NEXT_REL1 || cur_e.next == NEXT_REL2) && !rel_sum[8]);
    assign succ = (cur_e.next >= 0) ? cur_e.next[7:0] : rel_sum[7:0];

    // Request decode; a start outranks a step in the same cycle
    logic req_start, req_step_succ, req_step_sel;
    logic run_done, cont_switch;
    assign req_start = servo_on && start_rise && (state_q == S_IDLE || state_q == S_WAIT);
    assign req_step_succ = servo_on && step_rise && !start_rise && state_q == S_WAIT;
    assign req_step_sel = servo_on && step_rise && !start_rise && state_q == S_IDLE;
    assign run_done = state_q == S_RUN && mot_stopped;
    assign cont_switch = state_q == S_RUN && mot_target_reached && cur_e.link == LINK_CONT
        && succ_ok;

    // Sequencer next state
    always_comb begin
        state_d = state_q;
        if (!servo_on) begin
            state_d = S_IDLE;
        end else begin
            unique case (state_q)
                S_IDLE: begin
                    if (req_start || req_step_sel) begin
                        state_d = S_RUN;
                    end
                end
                S_RUN: begin
                    if (run_done) begin
                        unique case (cur_e.link)
                            LINK_NONE: state_d = S_IDLE;
                            LINK_MANUAL: state_d = succ_ok ? S_WAIT : S_IDLE;
                            LINK_AUTO: state_d = succ_ok ? S_DWELL : S_IDLE;
                            LINK_CONT: state_d = S_IDLE;
                        endcase
                    end
                end
                S_DWELL: begin
                    if (dwell_done) begin
                        state_d = S_RUN;
                    end
                end
                S_WAIT: begin
                    if (req_start || req_step_succ) begin
                        state_d = S_RUN;
                    end
                end
            endcase
        end
    end

    // Launch selection: which entry goes to the motion generator
    logic launch_d, blend_d;
    logic [7:0] launch_entry;
    ods_entry_t new_e;
    assign launch_d = req_start || req_step_sel || req_step_succ || cont_switch
        || (state_q == S_DWELL && dwell_done && servo_on);
    assign launch_entry = (req_start || req_step_sel) ? pins_s.sel : succ;
    assign blend_d = cont_switch;
    assign new_e = table_q[launch_entry];

    // Dwell between automatic entries, counted in ms
    ods_dwell #(.UNIT_CYC(DWELL_UNIT)) u_dwell (
        .pclk(pclk),
        .presetn(presetn),
        .load(run_done && cur_e.link == LINK_AUTO && succ_ok),
        .abort(!servo_on),
        .ms(cur_e.dwell),
        .done(dwell_done)
    );

    // Sequencer state, entry pointer and pin outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= S_IDLE;
            cur_q <= 8'h00;
            ready_q <= 1'b0;
            busy_q <= 1'b0;
        end else begin
            state_q <= state_d;
            if (launch_d) begin
                cur_q <= launch_entry;
            end
            ready_q <= servo_on && (state_d == S_IDLE || state_d == S_WAIT);
            busy_q <= state_d != S_IDLE;
        end
    end

    // Motion command: the launched entry's own rates and direction
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            launch_q <= 1'b0;
            cmd_q <= '0;
        end else begin
            launch_q <= launch_d;
            if (launch_d) begin
                cmd_q.entry <= launch_entry;
                cmd_q.accel <= new_e.accel;
                cmd_q.decel <= new_e.decel;
                cmd_q.rev <= new_e.rev;
                cmd_q.blend <= blend_d;
            end
        end
    end

    assign ready = ready_q;
    assign sequence_busy_flag = busy_q;
    assign mot_launch = launch_q;
    assign mot_cmd = cmd_q;

    // APB decode; writes act in the access phase
    logic wr_en, setup;
    logic hit_sel, hit_link, hit_dwell, hit_rate, hit_stat, mapped;
    ods_entry_t sel_e;
    assign setup = psel && !penable;
    assign wr_en = psel && penable && pwrite && !err_q;
    assign hit_sel = paddr == OFF_ENTRY_SEL;
    assign hit_link = paddr == OFF_ENTRY_LINK;
    assign hit_dwell = paddr == OFF_ENTRY_DWELL;
    assign hit_rate = paddr == OFF_ENTRY_RATE;
    assign hit_stat = paddr == OFF_STATUS;
    assign mapped = hit_sel || hit_link || hit_dwell || hit_rate || hit_stat;
    assign sel_e = table_q[sel_q];

    // Read word assembled before the access phase
    logic [31:0] rd_word;
    assign rd_word = hit_sel ? {24'h000000, sel_q} :
        hit_link ? {7'h00, sel_e.rev, 6'h00, sel_e.next, 6'h00, sel_e.link} :
        hit_dwell ? {16'h0000, sel_e.dwell} :
        hit_rate ? {sel_e.decel, sel_e.accel} :
        hit_stat ? {16'h0000, cur_q, 2'h0, state_q, 2'h0, busy_q, ready_q} : 32'h0;

    // Read data and error registered in setup so the slave never waits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0;
            err_q <= 1'b0;
        end else if (setup) begin
            prdata_q <= pwrite ? 32'h0 : rd_word;
            err_q <= !mapped || (pwrite && hit_stat);
        end
    end

    assign pready = 1'b1;
    assign prdata = prdata_q;
    assign pslverr = psel && penable && err_q;

    // Entry table; a rewrite mid-sequence changes the running entry's link, next and dwell at once, its rates and direction at the next launch
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_q <= 8'h00;
            for (int i = 0; i < 256; i++) begin
                table_q[i] <= ENTRY_RST;
            end
        end else if (wr_en) begin
            if (hit_sel) begin
                sel_q <= pwdata[7:0];
            end
            if (hit_link) begin
                table_q[sel_q].link <= ods_link_t'(pwdata[LINK_MODE_LSB +: 2]);
                table_q[sel_q].next <= pwdata[LINK_NEXT_LSB +: 10];
                table_q[sel_q].rev <= pwdata[LINK_REV_BIT];
            end
            if (hit_dwell) begin
                table_q[sel_q].dwell <= pwdata[15:0];
            end
            if (hit_rate) begin
                table_q[sel_q].accel <= pwdata[RATE_ACC_LSB +: 16];
                table_q[sel_q].decel <= pwdata[RATE_DEC_LSB +: 16];
            end
        end
    end

    // Checks on the sequencer
    a_start_drops_ready: assert property (@(posedge pclk) disable iff (!presetn)
        req_start |=> !ready && sequence_busy_flag && mot_launch)
        else $error("start did not drop ready and raise busy");

    a_single_ends: assert property (@(posedge pclk) disable iff (!presetn)
        (run_done && cur_e.link == LINK_NONE) |=> state_q == S_IDLE && !mot_launch)
        else $error("no-link entry did not end the sequence");

    a_manual_waits: assert property (@(posedge pclk) disable iff (!presetn)
        (servo_on && run_done && cur_e.link == LINK_MANUAL && succ_ok)
        |=> sequence_busy_flag && ready)
        else $error("manual entry did not wait busy and ready");

    a_step_successor: assert property (@(posedge pclk) disable iff (!presetn)
        req_step_succ |=> mot_launch && mot_cmd.entry == $past(succ))
        else $error("step did not launch linked successor");

    a_step_selected: assert property (@(posedge pclk) disable iff (!presetn)
        req_step_sel |=> mot_launch && mot_cmd.entry == $past(pins_s.sel))
        else $error("idle step did not launch selected entry");

    a_auto_dwell: assert property (@(posedge pclk) disable iff (!presetn)
        (servo_on && run_done && cur_e.link == LINK_AUTO && succ_ok)
        |=> state_q == S_DWELL ##1 !mot_launch)
        else $error("automatic entry did not dwell");

    a_cont_blend: assert property (@(posedge pclk) disable iff (!presetn)
        (servo_on && cont_switch) |=> mot_launch && mot_cmd.blend && state_q == S_RUN)
        else $error("continuous switch did not blend");

    a_chain_end: assert property (@(posedge pclk) disable iff (!presetn)
        (servo_on && $fell(sequence_busy_flag)) |-> ready)
        else $error("busy fell without ready");

    a_stop_code: assert property (@(posedge pclk) disable iff (!presetn)
        (cur_e.next == NEXT_STOP) |-> !succ_ok)
        else $error("stop code treated as successor");

    a_accel_next: assert property (@(posedge pclk) disable iff (!presetn)
        launch_d |=> mot_cmd.accel == $past(new_e.accel) && mot_cmd.decel == $past(new_e.decel))
        else $error("launch did not use next entry rates");

    // Dropping servo-on must clear both host outputs at once
    a_servo_abort: assert property (@(posedge pclk) disable iff (!presetn)
        !servo_on |=> !ready && !sequence_busy_flag)
        else $error("servo off did not clear ready and busy");

    // The motor stands still while the dwell runs
    a_dwell_hold: assert property (@(posedge pclk) disable iff (!presetn)
        state_q == S_DWELL |-> !mot_launch)
        else $error("launch during dwell");

    // A no-link entry never chains to another entry
    a_no_link_once: assert property (@(posedge pclk) disable iff (!presetn)
        (state_q == S_RUN && cur_e.link == LINK_NONE) |-> !launch_d)
        else $error("no-link entry launched a successor");

    // A continuous chain ends when its entry stops instead of blending
    a_cont_end: assert property (@(posedge pclk) disable iff (!presetn)
        (servo_on && run_done && cur_e.link == LINK_CONT) |=> !sequence_busy_flag && ready)
        else $error("continuous chain did not end on stop");

    // A start always takes the entry on the select pins
    a_start_sel: assert property (@(posedge pclk) disable iff (!presetn)
        req_start |=> mot_cmd.entry == $past(pins_s.sel))
        else $error("start did not launch selected entry");

    // Relative successor is the current entry plus one
    a_rel_next: assert property (@(posedge pclk) disable iff (!presetn)
        (state_q == S_WAIT && cur_e.next == NEXT_REL1 && cur_q != 8'hff)
        |-> succ_ok && succ == cur_q + 8'h01)
        else $error("relative successor wrong");

    // Direction and entry of the command follow the launched entry
    a_rev_cmd: assert property (@(posedge pclk) disable iff (!presetn)
        launch_d |=> mot_cmd.rev == $past(new_e.rev) && mot_cmd.entry == $past(launch_entry))
        else $error("launch direction or entry wrong");

    // A settled idle sequencer shows ready without busy
    a_idle_ready: assert property (@(posedge pclk) disable iff (!presetn)
        (state_q == S_IDLE && $past(state_q) == S_IDLE && servo_on && $past(servo_on))
        |-> ready && !sequence_busy_flag)
        else $error("idle without ready");

    // Writes to the status word are refused on the bus
    a_stat_write_err: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && penable && pwrite && hit_stat) |-> pslverr)
        else $error("status write not refused");

    // Requests arriving while an entry runs are ignored
    a_run_ignores: assert property (@(posedge pclk) disable iff (!presetn)
        (state_q == S_RUN && !cont_switch) |=> !mot_launch)
        else $error("launch while running without switch");

endmodule

// *** ods_sync.sv ***
`timescale 1ns/1ps
// Two-stage synchroniser for a group of pins
module ods_sync #(
    parameter int W = 1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_q;

    // First stage feeds only the second
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q <= '0;
            q <= '0;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule

// *** tb_operation_data_link_sequencer.sv ***
`timescale 1ns/1ps
module tb_operation_data_link_sequencer;
    import ods_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic ready, busy, tgt, stp, launch;
    ods_pins_t pins;
    ods_cmd_t cmd;
    ods_cmd_t seen[$];
    int at[$];
    int cyc = 0;
    int n_mismatch = 0;
    int n_compared = 0;

`define CHK(nm, exp, got) begin n_compared++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("[ERR] %s expected %h seen %h", nm, exp, got); end end

    ods_seq #(.DWELL_UNIT(4)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pins(pins), .ready(ready),
        .sequence_busy_flag(busy), .mot_target_reached(tgt), .mot_stopped(stp),
        .mot_launch(launch), .mot_cmd(cmd));
    ods_far i_far (.pclk(pclk), .ready(ready), .mot_launch(launch), .pins(pins),
        .mot_target_reached(tgt), .mot_stopped(stp));

    initial pclk = 1'b0;
    always #20 pclk = ~pclk;

    // Log every launch with its cycle so order and spacing can be judged later
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (launch === 1'b1) begin
            seen.push_back(cmd);
            at.push_back(cyc);
        end
    end

    task automatic wrap_up();
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Response is taken at the rising edge where pready is seen high, then released at once
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin @(posedge pclk); k++; end while (pready !== 1'b1 && k < 50);
        if (k >= 50) begin
            n_mismatch++;
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic set_entry(input logic [7:0] n, input logic [1:0] md, input logic [9:0] nx,
                             input logic rv, input logic [15:0] dw, input logic [31:0] rate);
        apb(1'b1, OFF_ENTRY_SEL, {24'h0, n});
        apb(1'b1, OFF_ENTRY_LINK, {7'h0, rv, 6'h0, nx, 6'h0, md});
        apb(1'b1, OFF_ENTRY_DWELL, {16'h0, dw});
        apb(1'b1, OFF_ENTRY_RATE, rate);
    endtask

    task automatic wait_for(input logic r, input logic b);
        int k = 0;
        do begin @(negedge pclk); k++; end while ((ready !== r || busy !== b) && k < 500);
        `CHK("ready", r, ready)
        `CHK("busy", b, busy)
    endtask

    task automatic next_cmd(output ods_cmd_t c, output int t);
        int k = 0;
        while (seen.size() == 0 && k < 500) begin @(negedge pclk); k++; end
        c = (seen.size() > 0) ? seen.pop_front() : '1;
        t = (at.size() > 0) ? at.pop_front() : 0;
    endtask

    // A hang ends the run as a failure
    initial begin
        #(60000 * 40);
        n_mismatch++;
        wrap_up();
    end

    initial begin
        ods_cmd_t c;
        int t0, t1;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (5) @(posedge pclk);
        `CHK("ready_rst", 1'b0, ready)
        `CHK("busy_rst", 1'b0, busy)
        presetn <= 1'b1;
        apb(1'b0, OFF_ENTRY_LINK, 32'h0);
        `CHK("link_rst", 32'h0003ff00, rd)
        apb(1'b0, 8'h14, 32'h0);
        `CHK("unmapped_err", 1'b1, er)
        apb(1'b1, OFF_STATUS, 32'h3);
        `CHK("status_wr_err", 1'b1, er)
        i_far.servo(1'b1);
        wait_for(1'b1, 1'b0);
        // Manual chain 0 -> 1 -> 5 through relative and absolute successors
        set_entry(8'h00, LINK_MANUAL, NEXT_REL1, 1'b0, 16'h0, 32'h0);
        set_entry(8'h01, LINK_MANUAL, 10'h005, 1'b0, 16'h0, 32'h0);
        set_entry(8'h05, LINK_NONE, NEXT_STOP, 1'b0, 16'h0, 32'h0);
        i_far.start_req(8'h00, 1'b0);
        wait_for(1'b0, 1'b1);
        next_cmd(c, t0);
        `CHK("man_first", 8'h00, c.entry)
        wait_for(1'b1, 1'b1);
        i_far.start_req(8'h33, 1'b1);
        next_cmd(c, t0);
        `CHK("man_second", 8'h01, c.entry)
        wait_for(1'b1, 1'b1);
        i_far.start_req(8'h33, 1'b1);
        next_cmd(c, t0);
        `CHK("man_abs", 8'h05, c.entry)
        wait_for(1'b1, 1'b0);
        `CHK("no_extra", 0, seen.size())
        // Step request while idle takes the selected entry
        i_far.start_req(8'h07, 1'b1);
        next_cmd(c, t0);
        `CHK("step_idle", 8'h07, c.entry)
        wait_for(1'b1, 1'b0);
        // Automatic chain 10 -> 12 with a dwell of 2 units of 4 cycles
        set_entry(8'h0a, LINK_AUTO, NEXT_REL2, 1'b0, 16'h0002, 32'h0);
        set_entry(8'h0c, LINK_NONE, NEXT_STOP, 1'b0, 16'h0, 32'h0);
        i_far.start_req(8'h0a, 1'b0);
        next_cmd(c, t0);
        next_cmd(c, t1);
        `CHK("auto_next", 8'h0c, c.entry)
        `CHK("auto_dwell", 1'b1, (t1 - t0 >= 15 && t1 - t0 <= 24))
        wait_for(1'b1, 1'b0);
        // Continuous chain 20 -> 21 (reversal) -> 22
        set_entry(8'h14, LINK_CONT, NEXT_REL1, 1'b0, 16'h0, 32'h02220111);
        set_entry(8'h15, LINK_CONT, NEXT_REL1, 1'b1, 16'h0, 32'h04440333);
        set_entry(8'h16, LINK_NONE, NEXT_STOP, 1'b0, 16'h0, 32'h06660555);
        i_far.start_req(8'h14, 1'b0);
        next_cmd(c, t0);
        next_cmd(c, t1);
        `CHK("cont_entry", 8'h15, c.entry)
        `CHK("cont_blend", 1'b1, c.blend)
        `CHK("cont_acc", 16'h0333, c.accel)
        `CHK("cont_rev_dec", 16'h0444, c.decel)
        `CHK("cont_rev", 1'b1, c.rev)
        next_cmd(c, t1);
        `CHK("cont_last", 8'h16, c.entry)
        `CHK("cont_stop_dec", 16'h0666, c.decel)
        wait_for(1'b1, 1'b0);
        // Manual entry whose successor is the stop code ends the chain
        set_entry(8'h1e, LINK_MANUAL, NEXT_STOP, 1'b0, 16'h0, 32'h0);
        i_far.start_req(8'h1e, 1'b0);
        next_cmd(c, t0);
        wait_for(1'b1, 1'b0);
        apb(1'b0, OFF_STATUS, 32'h0);
        `CHK("status", 2'b01, rd[1:0])
        wrap_up();
    end
endmodule
